/* File: ascr_pkg.sv */
// Package for the serial configuration register bank: offsets, field positions,
// reset values, frame layout and timing counts.
// Assumes a 50 MHz system clock and a four-wire serial link sampled on that clock.
`default_nettype none
package ascr_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLOCK_PERIOD_PS = 20000;
  localparam int SOFT_RESET_TIME_NS = 750;
  // Longest reset time rounds down to whole cycles
  localparam int SOFT_RESET_CYCLES = (SOFT_RESET_TIME_NS * 1000) / CLOCK_PERIOD_PS;
  localparam logic [5:0] SOFT_RESET_COUNT = 6'(SOFT_RESET_CYCLES);

  // ==========================================================================
  // Register byte addresses
  localparam logic [14:0] ADDR_SERIAL_INTERFACE_CONFIG = 15'h0000;
  localparam logic [14:0] ADDR_DEVICE_OPERATING_STATE = 15'h0002;
  localparam logic [14:0] ADDR_MAKER_ID_LO = 15'h000c;
  localparam logic [14:0] ADDR_MAKER_ID_HI = 15'h000d;
  localparam logic [14:0] ADDR_USER_SERIAL_OPTIONS = 15'h0010;
  localparam logic [14:0] ADDR_SYNC_REFERENCE_CONTROL = 15'h0029;
  localparam logic [14:0] ADDR_EDGE_POS_B0 = 15'h002c;
  localparam logic [14:0] ADDR_EDGE_POS_B1 = 15'h002d;
  localparam logic [14:0] ADDR_EDGE_POS_B2 = 15'h002e;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_SERIAL_INTERFACE_CONFIG = 8'h30;
  localparam logic [7:0] RST_DEVICE_OPERATING_STATE = 8'h00;
  localparam logic [7:0] RST_USER_SERIAL_OPTIONS = 8'h00;
  localparam logic [7:0] RST_SYNC_REFERENCE_CONTROL = 8'h80;
  // Arbitrary neutral maker code
  localparam logic [15:0] MAKER_CODE_DEFAULT = 16'h5a5a;

  // ==========================================================================
  // Field positions
  localparam int BIT_SOFT_RESET = 7;
  localparam int BIT_ADDR_ASCEND = 5;
  localparam int BIT_SEPARATE_OUTPUT_LINE = 4;
  localparam int BIT_ADDR_FREEZE = 0;
  localparam int BIT_PROC_ON = 6;
  localparam int BIT_RECV_ON = 5;
  localparam int BIT_FINE_SCALE = 4;
  localparam int DELAY_CHOICE_MSB = 3;
  localparam int STATE_FIELD_MSB = 1;
  localparam logic [1:0] STATE_POWER_DOWN = 2'h3;

  // ==========================================================================
  // Frame layout: 16-bit instruction (read flag, 15-bit address), then bytes
  localparam logic [3:0] INSTR_LAST_BIT = 4'hf;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam int INSTR_READ_BIT = 15;

  typedef enum logic [2:0] {
    ASCR_PH_IDLE = 3'b001,
    ASCR_PH_INSTR = 3'b010,
    ASCR_PH_DATA = 3'b100
  } ascr_phase_t;

endpackage : ascr_pkg
`default_nettype wire

/* File: ascr_pin_sync.sv */
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous inputs; output changes only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module ascr_pin_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire [WIDTH-1:0] disagree = stage2 ^ stage3;
  wire [WIDTH-1:0] next_level = (stage3 & ~disagree) | (level & disagree);

  always_ff @(posedge clock) begin
    if (!resetn) begin
      stage1 <= IDLE;
      stage2 <= IDLE;
      stage3 <= IDLE;
      level <= IDLE;
    end else begin
      stage1 <= pins;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= next_level;
    end
  end

endmodule : ascr_pin_sync
`default_nettype wire

/* File: ascr_regs.sv */
// First serial configuration register group of the converter, reached over a
// four-wire serial link (mode 0: sample on rising clock, shift out on falling).
// Assumes link pins are asynchronous to clock and the link clock is slower than
// one tenth of the system clock.
`timescale 1ns/1ps
`default_nettype none

module ascr_regs
  import ascr_pkg::*;
#(
  parameter logic [15:0] MAKER_CODE = MAKER_CODE_DEFAULT
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic spi_sclk,
  input wire logic spi_csn,
  input wire logic spi_sdi,
  output logic spi_sdo,
  input wire logic sync_ref_pin,
  input wire logic [23:0] sync_ref_edge_position,
  output logic chip_soft_reset,
  output logic device_powered_down,
  output logic sync_ref_processor_on,
  output logic sync_ref_receiver_on,
  output logic sync_ref_fine_delay_scale,
  output logic [3:0] sync_ref_delay_choice,
  output logic sync_ref_event
);

  // ==========================================================================
  // Pin synchronisers
  logic [3:0] pin_level;

  ascr_pin_sync #(
    .WIDTH(4),
    .IDLE(4'h2)
  ) u_pin_sync (
    .clock(clock),
    .resetn(resetn),
    .pins({sync_ref_pin, spi_sdi, spi_csn, spi_sclk}),
    .level(pin_level)
  );

  wire sclk_level = pin_level[0];
  wire csn_level = pin_level[1];
  wire sdi_level = pin_level[2];
  wire sync_level = pin_level[3];

  // ==========================================================================
  // Soft reset timer
  logic [5:0] soft_reset_left;
  wire soft_reset_busy = (soft_reset_left != 6'h00);
  wire regs_reset = !resetn || soft_reset_busy;

  // ==========================================================================
  // Register storage and frame state
  logic [7:0] serial_interface_config;
  logic [7:0] device_operating_state;
  logic [7:0] user_serial_options;
  logic [7:0] sync_reference_control;
  ascr_phase_t phase;
  logic [3:0] bit_count;
  logic [14:0] shift_in;
  logic [14:0] address;
  logic is_read;
  logic [7:0] shift_out;
  logic sclk_prev;
  logic sync_prev;

  wire sclk_rise = sclk_level && !sclk_prev;
  wire sclk_fall = !sclk_level && sclk_prev;
  wire frame_on = !csn_level;
  wire [15:0] instr_word = {shift_in, sdi_level};
  wire [7:0] data_byte = {shift_in[6:0], sdi_level};
  wire instr_done = (phase == ASCR_PH_INSTR) && sclk_rise && (bit_count == INSTR_LAST_BIT);
  wire byte_done = (phase == ASCR_PH_DATA) && sclk_rise && (bit_count[2:0] == BYTE_LAST_BIT);
  wire write_strobe = byte_done && !is_read;

  // Address stepping between stream bytes
  wire addr_freeze = user_serial_options[BIT_ADDR_FREEZE];
  wire addr_ascend = serial_interface_config[BIT_ADDR_ASCEND];
  wire [14:0] address_up = address + 15'h0001;
  wire [14:0] address_down = address - 15'h0001;
  wire [14:0] next_address = addr_freeze ? address :
                             (addr_ascend ? address_up : address_down);

  // Byte that the next read shifts out; the soft-reset bit reads as zero
  wire [14:0] read_address = (phase == ASCR_PH_INSTR) ? instr_word[14:0] : next_address;
  wire [7:0] config_view = {1'b0, serial_interface_config[6:5], 1'b1,
                            serial_interface_config[3:0]};
  logic [7:0] read_byte;

  always_comb begin
    case (read_address)
      ADDR_SERIAL_INTERFACE_CONFIG: read_byte = config_view;
      ADDR_DEVICE_OPERATING_STATE: read_byte = device_operating_state;
      ADDR_MAKER_ID_LO: read_byte = MAKER_CODE[7:0];
      ADDR_MAKER_ID_HI: read_byte = MAKER_CODE[15:8];
      ADDR_USER_SERIAL_OPTIONS: read_byte = user_serial_options;
      ADDR_SYNC_REFERENCE_CONTROL: read_byte = sync_reference_control;
      ADDR_EDGE_POS_B0: read_byte = sync_ref_edge_position[7:0];
      ADDR_EDGE_POS_B1: read_byte = sync_ref_edge_position[15:8];
      ADDR_EDGE_POS_B2: read_byte = sync_ref_edge_position[23:16];
      default: read_byte = 8'h00;
    endcase
  end

  // ==========================================================================
  // Write decode
  wire write_config = write_strobe && (address == ADDR_SERIAL_INTERFACE_CONFIG);
  wire write_state = write_strobe && (address == ADDR_DEVICE_OPERATING_STATE);
  wire write_options = write_strobe && (address == ADDR_USER_SERIAL_OPTIONS);
  wire write_sync_ctl = write_strobe && (address == ADDR_SYNC_REFERENCE_CONTROL);
  wire soft_reset_request = write_config && data_byte[BIT_SOFT_RESET];

  // Only a pulse starts the timer; the stored bit never holds a one
  always_ff @(posedge clock) begin
    if (!resetn) begin
      soft_reset_left <= 6'h00;
    end else if (soft_reset_request) begin
      soft_reset_left <= SOFT_RESET_COUNT;
    end else if (soft_reset_busy) begin
      soft_reset_left <= soft_reset_left - 6'h01;
    end
  end

  // Reserved bits are stored as written; the host keeps them at their defaults
  always_ff @(posedge clock) begin
    if (regs_reset) begin
      serial_interface_config <= RST_SERIAL_INTERFACE_CONFIG;
      device_operating_state <= RST_DEVICE_OPERATING_STATE;
      user_serial_options <= RST_USER_SERIAL_OPTIONS;
      sync_reference_control <= RST_SYNC_REFERENCE_CONTROL;
    end else begin
      if (write_config && !data_byte[BIT_SOFT_RESET]) begin
        serial_interface_config <= {1'b0, data_byte[6:5], 1'b1, data_byte[3:0]};
      end
      if (write_state) begin
        device_operating_state <= data_byte;
      end
      if (write_options) begin
        user_serial_options <= data_byte;
      end
      if (write_sync_ctl) begin
        sync_reference_control <= data_byte;
      end
    end
  end

  // ==========================================================================
  // Frame sequencer
  always_ff @(posedge clock) begin
    if (regs_reset || !frame_on) begin
      phase <= ASCR_PH_IDLE;
      bit_count <= 4'h0;
      shift_in <= 15'h0000;
      address <= 15'h0000;
      is_read <= 1'b0;
    end else begin
      case (phase)
        ASCR_PH_IDLE: begin
          phase <= ASCR_PH_INSTR;
        end
        ASCR_PH_INSTR: begin
          if (sclk_rise) begin
            shift_in <= instr_word[14:0];
            bit_count <= bit_count + 4'h1;
            if (instr_done) begin
              phase <= ASCR_PH_DATA;
              address <= instr_word[14:0];
              is_read <= instr_word[INSTR_READ_BIT];
            end
          end
        end
        ASCR_PH_DATA: begin
          if (sclk_rise) begin
            shift_in <= instr_word[14:0];
            bit_count <= {1'b0, bit_count[2:0] + 3'h1};
            if (byte_done) begin
              address <= next_address;
            end
          end
        end
        default: begin
          phase <= ASCR_PH_IDLE;
        end
      endcase
    end
  end

  // Read data always leave on the dedicated output line; a shared line is never used
  always_ff @(posedge clock) begin
    if (regs_reset || !frame_on) begin
      shift_out <= 8'h00;
      spi_sdo <= 1'b0;
    end else if (instr_done || (byte_done && is_read)) begin
      shift_out <= read_byte;
    end else if (sclk_fall && (phase == ASCR_PH_DATA) && is_read) begin
      spi_sdo <= shift_out[7];
      shift_out <= {shift_out[6:0], 1'b0};
    end
  end

  // ==========================================================================
  // Control outputs and sync event gating
  wire sync_rise = sync_level && !sync_prev;
  wire proc_on = sync_reference_control[BIT_PROC_ON];
  wire recv_on = sync_reference_control[BIT_RECV_ON];

  always_ff @(posedge clock) begin
    if (!resetn) begin
      sclk_prev <= 1'b0;
      sync_prev <= 1'b0;
      chip_soft_reset <= 1'b0;
    end else begin
      sclk_prev <= sclk_level;
      sync_prev <= sync_level;
      chip_soft_reset <= soft_reset_busy;
    end
  end

  // Outputs trail the registers by one cycle so every port comes from a flop
  always_ff @(posedge clock) begin
    if (regs_reset) begin
      device_powered_down <= 1'b0;
      sync_ref_processor_on <= 1'b0;
      sync_ref_receiver_on <= 1'b0;
      sync_ref_fine_delay_scale <= 1'b0;
      sync_ref_delay_choice <= 4'h0;
      sync_ref_event <= 1'b0;
    end else begin
      device_powered_down <= (device_operating_state[STATE_FIELD_MSB:0] ==
                              STATE_POWER_DOWN);
      sync_ref_processor_on <= proc_on;
      sync_ref_receiver_on <= recv_on;
      sync_ref_fine_delay_scale <= sync_reference_control[BIT_FINE_SCALE];
      sync_ref_delay_choice <= sync_reference_control[DELAY_CHOICE_MSB:0];
      // Does not rely on the host enabling the receiver first; both are required
      sync_ref_event <= sync_rise && proc_on && recv_on;
    end
  end

endmodule : ascr_regs
`default_nettype wire

/* File: ascr_host.sv */
// Host model that drives the four-wire serial link of the register bank.
// Assumes the bank's 50 MHz clock; link half period is ten of its cycles.
`timescale 1ns/1ps
`default_nettype none
module ascr_host (
  input wire logic clock,
  input wire logic spi_sdo,
  output logic spi_sclk,
  output logic spi_csn,
  output logic spi_sdi
);
  // Half link period well above the four cycles the synchronisers need
  localparam int HALF = 10;

  initial begin
    spi_sclk = 1'b0;
    spi_csn = 1'b1;
    spi_sdi = 1'b0;
  end

  // ==========================================================================
  // Link primitives
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  // Read data is taken from the separate output line only
  task automatic bit_io(input logic d, output logic s);
    spi_sdi = d;
    tick(HALF);
    spi_sclk = 1'b1;
    s = spi_sdo;
    tick(HALF);
    spi_sclk = 1'b0;
  endtask : bit_io

  // Byte k of wd and rdata sits at bits 8k+7:8k
  task automatic frame(input logic rd, input logic [14:0] a, input int nb,
                       input logic [31:0] wd, output logic [31:0] rdata);
    logic [15:0] instr;
    logic s;
    instr = {rd, a};
    rdata = '0;
    spi_csn = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      bit_io(instr[i], s);
    end
    for (int k = 0; k < nb; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bit_io(wd[8 * k + i], s);
        rdata[8 * k + i] = s;
      end
    end
    tick(HALF);
    spi_csn = 1'b1;
    // Released data line must not keep its last value
    spi_sdi = ~spi_sdi;
    tick(8);
  endtask : frame
endmodule : ascr_host
`default_nettype wire

/* File: ascr_regs_chk.sv */
// Concurrent checks on the ports of the register bank.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ascr_regs_chk
  import ascr_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic spi_sclk,
  input wire logic spi_csn,
  input wire logic spi_sdo,
  input wire logic chip_soft_reset,
  input wire logic device_powered_down,
  input wire logic sync_ref_processor_on,
  input wire logic sync_ref_receiver_on,
  input wire logic sync_ref_fine_delay_scale,
  input wire logic [3:0] sync_ref_delay_choice,
  input wire logic sync_ref_event
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // ==========================================================================
  // Soft reset length counter
  logic [5:0] sr_cnt;
  always_ff @(posedge clock) begin
    if (!resetn || !chip_soft_reset) begin
      sr_cnt <= '0;
    end else begin
      sr_cnt <= sr_cnt + 6'h1;
    end
  end

  // ==========================================================================
  // Assertions
  chk_reset_quiet: assert property ($rose(resetn) |-> !chip_soft_reset &&
    !device_powered_down && !sync_ref_processor_on && !sync_ref_receiver_on && !spi_sdo)
    else $error("outputs not cleared by reset");
  chk_soft_length: assert property ($fell(chip_soft_reset) |-> sr_cnt == SOFT_RESET_COUNT)
    else $error("soft reset length wrong");
  chk_soft_clears: assert property (chip_soft_reset [*3] |-> !device_powered_down &&
    !sync_ref_processor_on && !sync_ref_receiver_on && !sync_ref_fine_delay_scale &&
    sync_ref_delay_choice == 4'h0)
    else $error("soft reset left a control set");
  chk_soft_mutes: assert property (chip_soft_reset [*2] |-> !spi_sdo)
    else $error("read data during soft reset");
  chk_event_gated: assert property (sync_ref_event |->
    sync_ref_processor_on && sync_ref_receiver_on)
    else $error("sync event while disabled");
  chk_event_single: assert property (sync_ref_event |=> !sync_ref_event)
    else $error("sync event longer than one cycle");
  chk_cfg_framed: assert property ($changed({device_powered_down, sync_ref_processor_on,
    sync_ref_receiver_on, sync_ref_fine_delay_scale, sync_ref_delay_choice}) |->
    !spi_csn || chip_soft_reset)
    else $error("control changed outside a frame");
  chk_sdo_idle: assert property (spi_csn [*8] |-> !spi_sdo)
    else $error("output line busy while deselected");
  chk_sdo_on_low: assert property ($changed(spi_sdo) |-> !spi_sclk)
    else $error("output line moved while link clock high");

  cover property (sync_ref_event);
  cover property ($rose(chip_soft_reset));
  cover property ($rose(device_powered_down));
endmodule : ascr_regs_chk

bind ascr_regs ascr_regs_chk u_chk (
  .clock(clock), .resetn(resetn), .spi_sclk(spi_sclk), .spi_csn(spi_csn),
  .spi_sdo(spi_sdo), .chip_soft_reset(chip_soft_reset),
  .device_powered_down(device_powered_down), .sync_ref_processor_on(sync_ref_processor_on),
  .sync_ref_receiver_on(sync_ref_receiver_on),
  .sync_ref_fine_delay_scale(sync_ref_fine_delay_scale),
  .sync_ref_delay_choice(sync_ref_delay_choice), .sync_ref_event(sync_ref_event)
);
`default_nettype wire

/* File: ascr_regs_test.sv */
// Self-checking bench for the register bank, driven through the host model.
// Assumes a 50 MHz clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ascr_regs_test;
  import ascr_pkg::*;
  // Arbitrary maker code
  localparam logic [15:0] CODE = 16'h3c96;
  logic clock = 1'b0;
  logic resetn;
  logic spi_sclk;
  logic spi_csn;
  logic spi_sdi;
  logic spi_sdo;
  logic sync_ref_pin;
  logic [23:0] pos;
  logic [8:0] outs;
  logic ev;
  logic [31:0] q;
  int err_count;
  int cmp_count;
  int ev_cnt;

  ascr_regs #(.MAKER_CODE(CODE)) dut (
    .clock(clock), .resetn(resetn), .spi_sclk(spi_sclk), .spi_csn(spi_csn),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .sync_ref_pin(sync_ref_pin),
    .sync_ref_edge_position(pos), .chip_soft_reset(outs[8]), .device_powered_down(outs[7]),
    .sync_ref_processor_on(outs[6]), .sync_ref_receiver_on(outs[5]),
    .sync_ref_fine_delay_scale(outs[4]), .sync_ref_delay_choice(outs[3:0]),
    .sync_ref_event(ev)
  );
  ascr_host host (.clock(clock), .spi_sdo(spi_sdo), .spi_sclk(spi_sclk), .spi_csn(spi_csn),
    .spi_sdi(spi_sdi));

  always #10 clock = ~clock;
  always @(posedge clock) begin
    if (ev === 1'b1) ev_cnt++;
  end

  // ==========================================================================
  // Access and compare tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    host.frame(1'b0, a, 1, {24'h0, d}, q);
  endtask : wr
  task automatic rd(input logic [14:0] a, input int nb, input logic [31:0] exp);
    host.frame(1'b1, a, nb, 32'h0, q);
    check(q, exp, "read");
  endtask : rd
  task automatic pulse(input int n_exp);
    host.tick(1);
    sync_ref_pin = 1'b1;
    host.tick(10);
    sync_ref_pin = 1'b0;
    host.tick(10);
    check(ev_cnt, n_exp, "events");
  endtask : pulse
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  // ==========================================================================
  // Tests
  initial begin
    resetn = 1'b0;
    sync_ref_pin = 1'b0;
    pos = 24'hc3a51e;
    repeat (4) @(posedge clock);
    #1 resetn = 1'b1;
    host.tick(6);
    rd(ADDR_SERIAL_INTERFACE_CONFIG, 1, 32'h30);
    rd(ADDR_DEVICE_OPERATING_STATE, 1, 32'h00);
    rd(ADDR_USER_SERIAL_OPTIONS, 1, 32'h00);
    rd(ADDR_SYNC_REFERENCE_CONTROL, 1, 32'h80);
    check(outs, 9'h000, "outputs");
    rd(ADDR_MAKER_ID_LO, 2, {16'h0, CODE});
    wr(ADDR_MAKER_ID_LO, 8'hff);
    rd(ADDR_MAKER_ID_LO, 2, {16'h0, CODE});
    pulse(0);
    // Receiver first, reserved top bit kept at one
    wr(ADDR_SYNC_REFERENCE_CONTROL, 8'ha0);
    check(outs, 9'h020, "outputs");
    pulse(0);
    wr(ADDR_SYNC_REFERENCE_CONTROL, 8'he0);
    check(outs, 9'h060, "outputs");
    pulse(1);
    wr(ADDR_SYNC_REFERENCE_CONTROL, 8'hfb);
    check(outs, 9'h07b, "outputs");
    rd(ADDR_SYNC_REFERENCE_CONTROL, 1, 32'hfb);
    rd(ADDR_EDGE_POS_B0, 3, 32'hc3a51e);
    wr(ADDR_SERIAL_INTERFACE_CONFIG, 8'h00);
    rd(ADDR_SERIAL_INTERFACE_CONFIG, 1, 32'h10);
    rd(ADDR_EDGE_POS_B2, 3, 32'h1ea5c3);
    wr(ADDR_USER_SERIAL_OPTIONS, 8'h01);
    rd(ADDR_SYNC_REFERENCE_CONTROL, 2, 32'hfbfb);
    wr(ADDR_USER_SERIAL_OPTIONS, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_DEVICE_OPERATING_STATE, 8'(s));
      check(outs[7], 1'(s == 3), "power down");
      rd(ADDR_DEVICE_OPERATING_STATE, 1, 32'(s));
    end
    wr(ADDR_SERIAL_INTERFACE_CONFIG, 8'hb0);
    check(outs[8], 1'b1, "soft reset");
    host.tick(40);
    check(outs, 9'h000, "outputs");
    rd(ADDR_SERIAL_INTERFACE_CONFIG, 1, 32'h30);
    rd(ADDR_SYNC_REFERENCE_CONTROL, 1, 32'h80);
    rd(ADDR_DEVICE_OPERATING_STATE, 1, 32'h00);
    tally_and_finish();
  end

  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    tally_and_finish();
  end
endmodule : ascr_regs_test
`default_nettype wire
